// File: core/fbpdp_pkg.sv
package fbpdp_pkg;
  // Record layout: field widths and byte count
  localparam int REC_COUNTER_W = 16;
  localparam int REC_VELOCITY_W = 32;
  localparam int REC_RATE_W = 16;
  localparam int REC_LENGTH_W = 32;
  localparam int REC_ERROR_W = 8;
  localparam int REC_STATUS_W = 8;
  localparam int REC_TEMP_W = 8;
  localparam int REC_BYTES = 15;
  localparam int ACC_W = 48;

  // Status byte fields
  localparam int STS_ERROR_BIT = 0;
  localparam int STS_SIGNAL_BIT = 1;
  localparam int STS_VEL_NEG_BIT = 2;
  localparam int STS_LEN_NEG_BIT = 3;
  localparam logic [7:0] STS_RESET = 8'h00;

  // Control byte fields
  localparam int CTL_STANDBY0_BIT = 0;
  localparam int CTL_DIRECTION_BIT = 1;
  localparam int CTL_TRIGGER2_BIT = 2;
  localparam int CTL_TRIGGER1_BIT = 3;
  localparam int CTL_CLEAR_BIT = 4;
  localparam int CTL_SET_LO_BIT = 5;
  localparam int CTL_SET_HI_BIT = 6;
  localparam int CTL_RESTORE_BIT = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_TIME_MS = 500;
  localparam int WAKE_CYCLES = (WAKE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int DHCP_WAIT_MS = 1000;
  localparam int DHCP_WAIT_CYCLES = (DHCP_WAIT_MS * 1000000) / CLK_PERIOD_NS;

  // Fixed fallback address 192.168.0.51
  localparam logic [31:0] FALLBACK_ADDR = 32'hC0A80033;

  typedef enum logic [2:0] {
    FBPDP_IDLE = 3'b001,
    FBPDP_SEND = 3'b010,
    FBPDP_LAST = 3'b100
  } fbpdp_tx_type;
endpackage

// File: core/fbpdp_port.sv
`timescale 1ns/1ps
// Function
// - Each record carries counter16, velocity32, rate16, length32, error8, status8, temp8.
// - Velocity is in 10 um/s units, length in 0.1 mm units, rate in 0.1 percent units.
// - Velocity and length fields are magnitudes; their signs live only in the status byte.
// - The velocity sent is always unsigned and direction comes only from the status byte.
// - The sent length is the low 32 bits and wraps while the internal count runs on wider.
// - Status bits 7..4 read zero, bit 3 negative length, bit 2 negative speed, bit 1 signal, bit 0 error.
// - Control bit 0 held high holds standby when the source selection picks it.
// - Control bit 1 drives the sensor direction signal while held.
// - Control bit 2 is the second trigger, giving standby or gating external length.
// - Control bit 3 is the first trigger, gating length measurement externally.
// - A rising edge of control bit 4 clears the error entries; a steady level does nothing.
// - Control bits 6..5 pick a parameter set and bit 7 high makes the device load it.
// - Standby follows bit 2 when trigger2_is_standby is set and the source selection is 0, and bit 0 when the source selection is 1.
// - After standby ends the device is ready to measure within 500 ms.
// - The address comes from DHCP, falling back to 192.168.0.51 when no server answers.
module fbpdp_port
  import fbpdp_pkg::*;
#(
  parameter int WAKE_COUNT = fbpdp_pkg::WAKE_CYCLES,
  parameter int DHCP_COUNT = fbpdp_pkg::DHCP_WAIT_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Measurement from the sensor core
  input wire logic meas_valid,
  input wire logic signed [31:0] meas_velocity,
  input wire logic signed [47:0] meas_length,
  input wire logic [15:0] meas_rate,
  input wire logic [7:0] meas_error_num,
  input wire logic [7:0] meas_temp,
  input wire logic signal_acquired,
  input wire logic error_detected,
  // Record byte stream to the scanner
  output logic rec_valid,
  input wire logic rec_ready,
  output logic [7:0] rec_data,
  output logic rec_first,
  output logic rec_last,
  // Control byte from the scanner
  input wire logic host_control_byte_we,
  input wire logic [7:0] host_control_byte_in,
  output logic [7:0] device_status_byte,
  // Configuration
  input wire logic standby_select,
  input wire logic trigger2_is_standby,
  // Sensor controls
  output logic standby,
  output logic direction,
  output logic second_trigger_input,
  output logic first_trigger_input,
  output logic error_clear,
  output logic restore_req,
  output logic [1:0] restore_set,
  output logic ready_to_measure,
  // Network address
  input wire logic dhcp_valid,
  input wire logic [31:0] dhcp_addr,
  output logic [31:0] net_addr,
  output logic addr_fallback
);
  import fbpdp_pkg::*;

  localparam int WC_W = $clog2(WAKE_COUNT + 1);
  localparam int DC_W = $clog2(DHCP_COUNT + 1);

  function automatic logic [31:0] magnitude32(input logic signed [31:0] v);
    magnitude32 = v[31] ? 32'(-v) : 32'(v);
  endfunction

  logic [7:0] host_control_byte;
  logic clear_prev;
  logic restore_armed;
  logic [15:0] counter;
  logic [REC_BYTES*8-1:0] rec_shift;
  logic [3:0] byte_idx;
  fbpdp_tx_type tx_state;
  logic [WC_W-1:0] wake_cnt;
  logic standby_prev;
  logic [DC_W-1:0] dhcp_cnt;

  // Control byte decode
  wire ctl_standby0 = host_control_byte[CTL_STANDBY0_BIT];
  wire ctl_trig2 = host_control_byte[CTL_TRIGGER2_BIT];
  wire ctl_clear = host_control_byte[CTL_CLEAR_BIT];
  wire ctl_restore = host_control_byte[CTL_RESTORE_BIT];
  wire standby_src = standby_select ? ctl_standby0 : ctl_trig2;
  wire next_standby = standby_src & (standby_select | trigger2_is_standby);
  wire restore_fire = ctl_restore & restore_armed;
  wire clear_edge = ctl_clear & ~clear_prev;

  // Record assembly from magnitudes and signs
  wire [31:0] vel_mag = magnitude32(meas_velocity);
  wire [ACC_W-1:0] len_abs = meas_length[ACC_W-1] ? ACC_W'(-meas_length) : meas_length;
  wire [31:0] len_field = len_abs[31:0];
  wire [7:0] next_status = {4'h0, meas_length[ACC_W-1], meas_velocity[31],
    signal_acquired, error_detected};
  wire [REC_BYTES*8-1:0] next_record = {counter, vel_mag, meas_rate, len_field,
    meas_error_num, next_status, meas_temp};
  wire load_rec = meas_valid & (tx_state == FBPDP_IDLE);
  wire rec_fire = rec_valid & rec_ready;

  assign direction = host_control_byte[CTL_DIRECTION_BIT];
  assign first_trigger_input = host_control_byte[CTL_TRIGGER1_BIT];
  assign second_trigger_input = ctl_trig2 & ~trigger2_is_standby;
  assign restore_set = host_control_byte[CTL_SET_HI_BIT:CTL_SET_LO_BIT];
  assign rec_valid = (tx_state != FBPDP_IDLE);
  assign rec_data = rec_shift[REC_BYTES*8-1 -: 8];
  assign rec_first = (tx_state != FBPDP_IDLE) & (byte_idx == 4'h0);
  assign rec_last = (tx_state == FBPDP_LAST);

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      host_control_byte <= CTL_RESET;
      clear_prev <= 1'b0;
      restore_armed <= 1'b1;
      error_clear <= 1'b0;
      restore_req <= 1'b0;
      standby <= 1'b0;
    end
    else if (clk_en)
    begin
      if (host_control_byte_we)
        host_control_byte <= host_control_byte_in;
      clear_prev <= ctl_clear;
      error_clear <= clear_edge;
      restore_req <= restore_fire;
      // Rearm only after the scanner has dropped bit 7
      restore_armed <= ~ctl_restore;
      standby <= next_standby;
    end
  end

  // Record transmitter
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      tx_state <= FBPDP_IDLE;
      rec_shift <= '0;
      byte_idx <= 4'h0;
      counter <= 16'h0000;
      device_status_byte <= STS_RESET;
    end
    else if (clk_en)
    begin
      case (tx_state)
        FBPDP_IDLE:
        begin
          if (load_rec)
          begin
            rec_shift <= next_record;
            device_status_byte <= next_status;
            counter <= counter + 16'h0001;
            byte_idx <= 4'h0;
            tx_state <= FBPDP_SEND;
          end
        end
        FBPDP_SEND:
        begin
          if (rec_fire)
          begin
            rec_shift <= {rec_shift[REC_BYTES*8-9:0], 8'h00};
            byte_idx <= byte_idx + 4'h1;
            if (byte_idx == 4'(REC_BYTES - 2))
              tx_state <= FBPDP_LAST;
          end
        end
        FBPDP_LAST:
        begin
          if (rec_fire)
          begin
            byte_idx <= 4'h0;
            tx_state <= FBPDP_IDLE;
          end
        end
        default:
          tx_state <= FBPDP_IDLE;
      endcase
    end
  end

  // Wake-up timer after standby release; a shorter core start is fine
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      wake_cnt <= '0;
      standby_prev <= 1'b0;
      ready_to_measure <= 1'b1;
    end
    else if (clk_en)
    begin
      standby_prev <= standby;
      if (standby)
      begin
        ready_to_measure <= 1'b0;
        wake_cnt <= '0;
      end
      else if (!ready_to_measure)
      begin
        wake_cnt <= wake_cnt + 1'b1;
        if (wake_cnt == WC_W'(WAKE_COUNT - 1))
          ready_to_measure <= 1'b1;
      end
    end
  end

  // Address: DHCP whenever answered, else the fixed fallback once the wait runs out
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      dhcp_cnt <= '0;
      net_addr <= 32'h00000000;
      addr_fallback <= 1'b0;
    end
    else if (clk_en)
    begin
      if (dhcp_valid)
      begin
        net_addr <= dhcp_addr;
        addr_fallback <= 1'b0;
      end
      else if (net_addr == 32'h00000000)
      begin
        if (dhcp_cnt == DC_W'(DHCP_COUNT - 1))
        begin
          net_addr <= FALLBACK_ADDR;
          addr_fallback <= 1'b1;
        end
        else
          dhcp_cnt <= dhcp_cnt + 1'b1;
      end
    end
  end

  // Restore handshake steps
  sequence restore_rise_s;
    clk_en && host_control_byte[CTL_RESTORE_BIT] && restore_armed;
  endsequence

  // Bit 7 seen high on two enabled edges in a row
  sequence restore_held_s;
    clk_en && ctl_restore ##1 clk_en && ctl_restore;
  endsequence

  // Clear bit already high on the previous edge: a steady level
  sequence clear_steady_s;
    clk_en && ctl_clear && clear_prev;
  endsequence

  // A record is captured by the idle transmitter
  sequence rec_start_s;
    clk_en && load_rec;
  endsequence

  restore_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
    restore_rise_s |=> restore_req)
    else $error("restore not issued");

  restore_once_a: assert property (@(posedge ref_clk) disable iff (reset)
    restore_req && clk_en && $stable(host_control_byte) |=> !restore_req)
    else $error("restore repeated");

  restore_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    restore_held_s |=> !restore_req)
    else $error("restore while bit 7 held");

  clear_edge_a: assert property (@(posedge ref_clk) disable iff (reset)
    error_clear |-> $past(clk_en) && $past(clear_edge))
    else $error("clear without edge");

  clear_level_a: assert property (@(posedge ref_clk) disable iff (reset)
    clear_steady_s |=> !error_clear)
    else $error("clear on steady level");

  status_res_a: assert property (@(posedge ref_clk) disable iff (reset)
    device_status_byte[7:4] == 4'h0)
    else $error("status reserved bits set");

  status_sign_a: assert property (@(posedge ref_clk) disable iff (reset)
    rec_start_s |=> device_status_byte[STS_LEN_NEG_BIT] == $past(meas_length[ACC_W-1])
      && device_status_byte[STS_VEL_NEG_BIT] == $past(meas_velocity[31]))
    else $error("status sign bits wrong");

  standby_src_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && standby_select && ctl_standby0 |=> standby)
    else $error("standby select ignored");

  standby_dflt_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && !standby_select && trigger2_is_standby && ctl_trig2 |=> standby)
    else $error("standby from bit 2 ignored");

  standby_drop_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && !standby_src |=> !standby)
    else $error("standby without source");

  trig2_route_a: assert property (@(posedge ref_clk) disable iff (reset)
    trigger2_is_standby |-> !second_trigger_input)
    else $error("trigger 2 leaks in standby mode");

  trig1_follow_a: assert property (@(posedge ref_clk) disable iff (reset)
    first_trigger_input == host_control_byte[CTL_TRIGGER1_BIT])
    else $error("trigger 1 mismatch");

  direction_a: assert property (@(posedge ref_clk) disable iff (reset)
    direction == host_control_byte[CTL_DIRECTION_BIT])
    else $error("direction mismatch");

  // Velocity sits right behind the two counter bytes
  velocity_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && load_rec |=> rec_shift[13*8-1 -: 32] == magnitude32($past(meas_velocity)))
    else $error("velocity not magnitude");

  length_wrap_a: assert property (@(posedge ref_clk) disable iff (reset)
    rec_start_s |=> rec_shift[7*8-1 -: 32] == 32'($past(len_abs)))
    else $error("length field not wrapped");

  record_len_a: assert property (@(posedge ref_clk) disable iff (reset)
    rec_first && rec_fire && clk_en |=> !rec_first && rec_valid)
    else $error("record ended early");

  record_start_a: assert property (@(posedge ref_clk) disable iff (reset)
    rec_start_s |=> rec_first && rec_valid && !rec_last)
    else $error("record start missing");

  counter_step_a: assert property (@(posedge ref_clk) disable iff (reset)
    rec_start_s |=> counter == $past(counter) + 16'h0001)
    else $error("record counter not stepped");

  // Readiness must be withdrawn as soon as standby is seen
  wake_drop_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && standby |=> !ready_to_measure)
    else $error("ready during standby");

  wake_restart_a: assert property (@(posedge ref_clk) disable iff (reset)
    standby_prev && !standby |-> !ready_to_measure && wake_cnt == '0)
    else $error("wake timer not restarted");

  addr_fallback_a: assert property (@(posedge ref_clk) disable iff (reset)
    addr_fallback |-> net_addr == FALLBACK_ADDR)
    else $error("fallback address wrong");

  dhcp_take_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && dhcp_valid |=> net_addr == $past(dhcp_addr) && !addr_fallback)
    else $error("offered address not taken");
endmodule

// File: tb/fbpdp_scanner.sv
`timescale 1ns/1ps
module fbpdp_scanner
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Record stream
  input wire logic rec_valid,
  input wire logic [7:0] rec_data,
  input wire logic rec_last,
  output logic rec_ready,
  // Collected record
  output logic [119:0] rec_word,
  output int n_rec
);
  logic [7:0] stall;
  initial
  begin
    rec_ready = 1'b0;
    rec_word = '0;
    n_rec = 0;
    stall = 8'hA5;
  end
  // Stalls about one byte in four so the stream is seen to hold its byte
  always @(posedge ref_clk)
  begin
    stall <= {stall[6:0], stall[7] ^ stall[5] ^ stall[4] ^ stall[3]};
    rec_ready <= !reset && (stall[0] | stall[1]);
    if (rec_valid && rec_ready)
    begin
      rec_word <= {rec_word[111:0], rec_data};
      if (rec_last)
        n_rec <= n_rec + 1;
    end
  end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fbpdp_pkg::*;
  logic ref_clk = 0, reset = 1, clk_en = 1, meas_valid = 0, signal_acquired = 0;
  logic error_detected = 0, rec_valid, rec_ready, rec_first, rec_last, host_control_byte_we = 0;
  logic signed [31:0] meas_velocity = 0;
  logic signed [47:0] meas_length = 0;
  logic [15:0] meas_rate = 0;
  logic [7:0] meas_error_num = 0, meas_temp = 0, rec_data, host_control_byte_in = 0;
  logic [7:0] device_status_byte;
  logic standby_select = 0, trigger2_is_standby = 0, standby, direction, error_clear;
  logic second_trigger_input, first_trigger_input, restore_req, ready_to_measure;
  logic [1:0] restore_set, last_set;
  logic dhcp_valid = 0, addr_fallback;
  logic [31:0] dhcp_addr = 0, net_addr, seed = 32'h22d4, m_vel, m_len;
  logic [119:0] rec_word;
  logic [7:0] v;
  int n_rec, n_errors = 0, compares = 0, cyc = 0, n_clr = 0, n_rst = 0, w;
  fbpdp_port #(.WAKE_COUNT(20), .DHCP_COUNT(30)) uut (.ref_clk, .reset, .clk_en, .meas_valid,
    .meas_velocity, .meas_length, .meas_rate, .meas_error_num, .meas_temp, .signal_acquired,
    .error_detected, .rec_valid, .rec_ready, .rec_data, .rec_first, .rec_last,
    .host_control_byte_we, .host_control_byte_in, .device_status_byte, .standby_select,
    .trigger2_is_standby, .standby, .direction, .second_trigger_input, .first_trigger_input,
    .error_clear, .restore_req, .restore_set, .ready_to_measure, .dhcp_valid, .dhcp_addr,
    .net_addr, .addr_fallback);
  fbpdp_scanner partner (.ref_clk, .reset, .rec_valid, .rec_data, .rec_last, .rec_ready,
    .rec_word, .n_rec);
  always #5 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string name, input logic [119:0] exp, input logic [119:0] seen);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Pulses last one cycle, so they are counted at every edge
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (error_clear === 1'b1)
      n_clr <= n_clr + 1;
    if (restore_req === 1'b1)
    begin
      n_rst <= n_rst + 1;
      last_set <= restore_set;
    end
    if (cyc == 6000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic wr(input logic [7:0] b);
    @(posedge ref_clk);
    host_control_byte_we <= 1;
    host_control_byte_in <= b;
    @(posedge ref_clk);
    host_control_byte_we <= 0;
    @(posedge ref_clk);
    #1;
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset <= 0;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge ref_clk);
      meas_velocity <= (k == 0) ? -32'sd3 : $signed(rnd() >> (k % 2));
      meas_length <= (k == 1) ? 48'sh0002_0000_0007 : (k == 2) ? -48'sd9 : {rnd(), rnd()};
      {meas_rate, meas_error_num, meas_temp} <= rnd();
      {signal_acquired, error_detected} <= rnd();
      meas_valid <= 1;
      @(posedge ref_clk);
      meas_valid <= 0;
      w = n_rec;
      for (int t = 0; t < 200 && n_rec == w; t++)
        @(posedge ref_clk);
      #1;
      m_vel = meas_velocity[31] ? -meas_velocity : meas_velocity;
      m_len = meas_length[47] ? 32'(-meas_length) : meas_length[31:0];
      v = {4'h0, meas_length[47], meas_velocity[31], signal_acquired, error_detected};
      check("record", {16'(k), m_vel, meas_rate, m_len, meas_error_num, v, meas_temp},
        rec_word);
      check("status", v, device_status_byte);
    end
    $display("test record done");
    for (int k = 0; k < 12; k++)
    begin
      v = rnd() & 32'h0F;
      {standby_select, trigger2_is_standby} <= 2'(k);
      wr(v);
      check("direction", v[1], direction);
      check("trigger1", v[3], first_trigger_input);
      check("trigger2", v[2] & ~trigger2_is_standby, second_trigger_input);
      check("standby", standby_select ? v[0] : v[2] & trigger2_is_standby,
        standby);
    end
    $display("test control done");
    standby_select <= 1;
    wr(8'h01);
    @(posedge ref_clk);
    #1;
    check("wake low", 0, ready_to_measure);
    wr(8'h00);
    repeat (8) @(posedge ref_clk);
    #1;
    check("wake early", 0, ready_to_measure);
    repeat (14) @(posedge ref_clk);
    #1;
    check("wake", 1, ready_to_measure);
    $display("test wake done");
    w = n_clr;
    wr(8'h10);
    wr(8'h10);
    wr(8'h00);
    wr(8'h10);
    @(posedge ref_clk);
    #1;
    check("clears", w + 2, n_clr);
    w = n_rst;
    wr(8'hC0);
    @(posedge ref_clk);
    #1;
    check("set two", 2, last_set);
    wr(8'hC0);
    wr(8'h00);
    wr(8'hA0);
    wr(8'h00);
    check("restores", w + 2, n_rst);
    check("set one", 1, last_set);
    $display("test restore done");
    // With the enable low a write must not reach the control byte
    clk_en <= 0;
    wr(8'h02);
    check("frozen", 0, direction);
    clk_en <= 1;
    wr(8'h02);
    check("thawed", 1, direction);
    $display("test enable done");
    check("fallback", {1'b1, 32'hC0A80033}, {addr_fallback, net_addr});
    dhcp_addr <= 32'h0A000005;
    dhcp_valid <= 1;
    repeat (2) @(posedge ref_clk);
    #1;
    check("dhcp", {1'b0, 32'h0A000005}, {addr_fallback, net_addr});
    $display("test address done");
    print_verdict();
  end
endmodule
